// File: rtl/adcsw_regs.svh
// Constants of the converter control block
`ifndef ADCSW_REGS_SVH
`define ADCSW_REGS_SVH
`define ADCSW_REG_SEL_BIT      7
`define ADCSW_CLK_SRC_BIT      3
`define ADCSW_START_MODE_BIT   5
`define ADCSW_INT_MODE_BIT     2
`define ADCSW_OSC_SPEED_BIT    4
`define ADCSW_CODING_BIT       1
`define ADCSW_CR0_RESET        8'h00
`define ADCSW_CR1_RESET        8'h40
`define ADCSW_SAMPLE_CYCLES    4'h6
`define ADCSW_CONVERT_CYCLES   4'ha
`define ADCSW_SYS_PERIOD_NS    100
`define ADCSW_CLK_PERIOD_NS    20
`define ADCSW_SYS_DIV          (`ADCSW_SYS_PERIOD_NS / `ADCSW_CLK_PERIOD_NS)
`endif

// File: rtl/adcsw_pkg.sv
// State types of the converter end and of the host end of the link
package adcsw_pkg;
   typedef enum logic [2:0] {
      ADCSW_IDLE,
      ADCSW_SAMPLE,
      ADCSW_CONVERT,
      ADCSW_WAIT_READ,
      ADCSW_POWER_DOWN
   } adcsw_state_t;
   typedef enum logic [2:0] {
      ADCSW_H_IDLE,
      ADCSW_H_WRITE,
      ADCSW_H_READ,
      ADCSW_H_HOLD
   } adcsw_host_state_t;
endpackage

// File: rtl/adcsw_if.sv
// Parallel bus between host and converter
`timescale 1ns/1ps
`default_nettype none
interface adcsw_if;
   logic       cs_n;
   logic       wr_n;
   logic       rd_n;
   logic       hardware_convert_trigger_n;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic       int_eoc_n;
   logic [7:0] bus_data;
   assign bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
   modport device (input cs_n, wr_n, rd_n, hardware_convert_trigger_n, bus_data,
                   output dev_data, dev_data_oe, int_eoc_n);
   modport host   (output cs_n, wr_n, rd_n, hardware_convert_trigger_n, host_data, host_data_oe,
                   input bus_data, int_eoc_n);
endinterface
`default_nettype wire

// File: rtl/adcsw_device.sv
// Converter end: control registers, sequencer, result output
//
// What the document requires
// [R1] Sampling starts on write strobe rising edge
// [R2] Conversion starts six system clocks after sampling
// [R3] Internal clock starts at triggering write edge; code starts it at any strobe edge, falling ones included
// [R4] Internal clock gated off after each conversion
// [R5] Later samplings start on read rising edge
// [R6] Control zero bit 3 picks clock source
// [R7] Source switches at programming write edge
// [R8] Internal clock starts within half period
// [R9] Control one bit 4 sets oscillator speed
// [R10] Host supplies external clock 1 to 20 MHz
// [R11] Eight-bit result, binary or twos complement
// [R12] Host lowers chip select before any cycle
// [R13] Status line high after power-up
// [R14] Host writes both control registers after power-up
// [R15] Host discards first result after power-down
// [R16] Full rate needs 20 MHz system clock
// [R17] Eight-bit data bus, strobes, status line
// [R18] Conversion lasts ten system clocks
// [R19] End-of-conversion level or one interrupt pulse
// [R20] Result valid at status rising edge
// [R21] No read one clock after: power down
// [R22] Drive result while chip select and read low
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adcsw_regs.svh"
module adcsw_device #(
   parameter int unsigned SYS_DIV = `ADCSW_SYS_DIV
) (
   input  wire logic    clock,
   input  wire logic    resetn,
   adcsw_if.device      bus,
   input  wire logic    external_clock_en,
   input  wire logic [7:0] analog_sample,
   output logic         internal_oscillator_run,
   output logic         conversion_clock_en,
   output logic         power_down
);
   adcsw_pkg::adcsw_state_t state_q;
   logic [7:0] control_reg_zero_q;
   logic [7:0] control_reg_one_q;
   logic       wr_n_q;
   logic       rd_n_q;
   logic       cst_n_q;
   logic       wr_rise;
   logic       rd_rise;
   logic       cst_fall;
   logic       cst_rise;
   logic       trig_fall;
   logic [3:0] cyc_q;
   logic [7:0] held_q;
   logic [7:0] result_q;
   logic       first_done_q;
   logic       osc_run_q;
   logic [7:0] div_q;
   logic       osc_tick;
   logic       sys_tick;
   logic       clock_source_select;
   logic       start_mode_select;
   logic       int_mode;
   logic       int_pulse_q;
   logic       eoc_n_q;
   logic [7:0] div_limit;

   assign clock_source_select = control_reg_zero_q[`ADCSW_CLK_SRC_BIT];     // see [R6]
   assign start_mode_select   = control_reg_zero_q[`ADCSW_START_MODE_BIT];
   assign int_mode            = control_reg_zero_q[`ADCSW_INT_MODE_BIT];
   assign wr_rise   = !wr_n_q && bus.wr_n && !bus.cs_n;                       // see [R1]
   assign rd_rise   = !rd_n_q && bus.rd_n && !bus.cs_n;
   assign cst_fall  = cst_n_q && !bus.hardware_convert_trigger_n;
   assign cst_rise  = !cst_n_q && bus.hardware_convert_trigger_n;
   assign trig_fall = (wr_n_q && !bus.wr_n) || (rd_n_q && !bus.rd_n) || cst_fall;

   // ------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_n_q  <= 1'b1;
         rd_n_q  <= 1'b1;
         cst_n_q <= 1'b1;
      end else begin
         wr_n_q  <= bus.wr_n;
         rd_n_q  <= bus.rd_n;
         cst_n_q <= bus.hardware_convert_trigger_n;
      end
   end

   // ------------------------------------------------------------
   // Control registers, bit 7 selects the register
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         control_reg_zero_q <= `ADCSW_CR0_RESET;
         control_reg_one_q  <= `ADCSW_CR1_RESET;
      end else if (wr_rise) begin                                            // see [R7]
         if (bus.bus_data[`ADCSW_REG_SEL_BIT] == 1'b0)
            control_reg_zero_q <= bus.bus_data;                              // see [R6]
         else
            control_reg_one_q <= bus.bus_data;                               // see [R9]
      end
   end

   // ------------------------------------------------------------
   // Internal oscillator model: divider, speed cuts period to half, rounded up
   // ------------------------------------------------------------
   assign div_limit = control_reg_one_q[`ADCSW_OSC_SPEED_BIT]                // see [R9] [R16]
                      ? 8'((SYS_DIV + 1) / 2 - 1) : 8'(SYS_DIV - 1);
   assign osc_tick  = osc_run_q && (div_q == div_limit);
   assign sys_tick  = clock_source_select ? external_clock_en : osc_tick;    // see [R6]

   always_ff @(posedge clock) begin
      if (!resetn || !osc_run_q)
         div_q <= 8'h00;
      else if (osc_tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   always_ff @(posedge clock) begin
      if (!resetn)
         osc_run_q <= 1'b0;
      else if (clock_source_select)
         osc_run_q <= 1'b0;
      else if (trig_fall || wr_rise || rd_rise)                              // see [R3] [R8]
         osc_run_q <= 1'b1;
      else if (state_q == adcsw_pkg::ADCSW_WAIT_READ || state_q == adcsw_pkg::ADCSW_POWER_DOWN)
         osc_run_q <= 1'b0;                                                  // see [R4]
   end

   // ------------------------------------------------------------
   // Sample / convert sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q      <= adcsw_pkg::ADCSW_IDLE;
         cyc_q        <= 4'h0;
         first_done_q <= 1'b0;
      end else begin
         unique case (state_q)
            adcsw_pkg::ADCSW_IDLE, adcsw_pkg::ADCSW_WAIT_READ, adcsw_pkg::ADCSW_POWER_DOWN: begin
               if (start_mode_select && ((!first_done_q && wr_rise) || (first_done_q && rd_rise))) begin
                  state_q <= adcsw_pkg::ADCSW_SAMPLE;                        // see [R1] [R5]
                  cyc_q   <= 4'h0;
               end else if (!start_mode_select && cst_fall) begin
                  state_q <= adcsw_pkg::ADCSW_SAMPLE;
                  cyc_q   <= 4'h0;
               end else if (state_q == adcsw_pkg::ADCSW_WAIT_READ &&
                            (sys_tick || (!clock_source_select && !osc_run_q))) begin
                  // Gated oscillator gives no further tick, so its stop ends the wait
                  state_q <= adcsw_pkg::ADCSW_POWER_DOWN;                    // see [R21]
               end
               if (!start_mode_select)
                  first_done_q <= 1'b0;
            end
            adcsw_pkg::ADCSW_SAMPLE: begin
               if (start_mode_select && sys_tick) begin
                  if (cyc_q == `ADCSW_SAMPLE_CYCLES - 4'h1) begin            // see [R2]
                     state_q <= adcsw_pkg::ADCSW_CONVERT;
                     cyc_q   <= 4'h0;
                  end else
                     cyc_q <= cyc_q + 4'h1;
               end else if (!start_mode_select && cst_rise) begin
                  state_q <= adcsw_pkg::ADCSW_CONVERT;
                  cyc_q   <= 4'h0;
               end
            end
            adcsw_pkg::ADCSW_CONVERT: begin
               if (sys_tick) begin
                  if (cyc_q == `ADCSW_CONVERT_CYCLES - 4'h1) begin           // see [R18]
                     state_q      <= adcsw_pkg::ADCSW_WAIT_READ;
                     first_done_q <= start_mode_select;
                  end else
                     cyc_q <= cyc_q + 4'h1;
               end
            end
            default: state_q <= adcsw_pkg::ADCSW_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Held sample and coded result
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn)
         held_q <= 8'h00;
      else if (state_q == adcsw_pkg::ADCSW_SAMPLE && (sys_tick || cst_rise))
         held_q <= analog_sample;
   end

   always_ff @(posedge clock) begin
      if (!resetn)
         result_q <= 8'h00;
      else if (state_q == adcsw_pkg::ADCSW_CONVERT && sys_tick &&
               cyc_q == `ADCSW_CONVERT_CYCLES - 4'h1)                        // see [R20]
         result_q <= control_reg_one_q[`ADCSW_CODING_BIT]
                     ? {~held_q[7], held_q[6:0]} : held_q;                   // see [R11]
   end

   // ------------------------------------------------------------
   // Status line: level or pulse
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         eoc_n_q     <= 1'b1;                                                // see [R13]
         int_pulse_q <= 1'b0;
      end else begin
         eoc_n_q     <= !(state_q == adcsw_pkg::ADCSW_CONVERT &&
                          !(sys_tick && cyc_q == `ADCSW_CONVERT_CYCLES - 4'h1)); // see [R19]
         int_pulse_q <= state_q == adcsw_pkg::ADCSW_CONVERT && sys_tick &&
                        cyc_q == `ADCSW_CONVERT_CYCLES - 4'h1;
      end
   end

   assign bus.int_eoc_n = int_mode ? !int_pulse_q : eoc_n_q;                 // see [R19] [R20]
   assign bus.dev_data    = result_q;
   assign bus.dev_data_oe = !bus.cs_n && !bus.rd_n;                          // see [R22] [R17]
   assign internal_oscillator_run = osc_run_q;
   assign conversion_clock_en     = sys_tick;
   assign power_down              = state_q == adcsw_pkg::ADCSW_POWER_DOWN || bus.cs_n;
endmodule
`default_nettype wire

// File: rtl/adcsw_host.sv
// Host end: register port in, parallel bus cycles out
`timescale 1ns/1ps
`default_nettype none
`include "adcsw_regs.svh"
module adcsw_host #(
   parameter int unsigned STROBE_CYCLES = 2
) (
   input  wire logic       clock,
   input  wire logic       resetn,
   adcsw_if.host           bus,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_strobe,
   input  wire logic       rd_strobe,
   output logic [7:0]      rdata,
   output logic            hardware_start_level
);
   // addr 0: write = bus write cycle, addr 1: write = bus read cycle,
   // addr 2: bit0 drives hardware trigger (active low level)
   // read addr 0: last result, addr 1: {busy, done, status line}
   adcsw_pkg::adcsw_host_state_t state_q;
   logic [7:0] wbuf_q;
   logic [7:0] result_q;
   logic [7:0] cnt_q;
   logic       is_write_q;
   logic       done_q;
   logic       trig_q;
   logic       busy;

   assign busy = state_q != adcsw_pkg::ADCSW_H_IDLE;

   // ------------------------------------------------------------
   // Bus cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q    <= adcsw_pkg::ADCSW_H_IDLE;
         cnt_q      <= 8'h00;
         is_write_q <= 1'b0;
         wbuf_q     <= 8'h00;
      end else begin
         unique case (state_q)
            adcsw_pkg::ADCSW_H_IDLE: begin
               if (wr_strobe && addr == 2'h0) begin                          // see [R14]
                  state_q    <= adcsw_pkg::ADCSW_H_WRITE;
                  is_write_q <= 1'b1;
                  wbuf_q     <= wdata;
                  cnt_q      <= 8'h00;
               end else if (wr_strobe && addr == 2'h1) begin
                  state_q    <= adcsw_pkg::ADCSW_H_READ;
                  is_write_q <= 1'b0;
                  cnt_q      <= 8'h00;
               end
            end
            adcsw_pkg::ADCSW_H_WRITE, adcsw_pkg::ADCSW_H_READ: begin
               if (cnt_q == 8'(STROBE_CYCLES - 1))
                  state_q <= adcsw_pkg::ADCSW_H_HOLD;
               else
                  cnt_q <= cnt_q + 8'h01;
            end
            adcsw_pkg::ADCSW_H_HOLD: state_q <= adcsw_pkg::ADCSW_H_IDLE;
            default: state_q <= adcsw_pkg::ADCSW_H_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Captured result and done flag
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         result_q <= 8'h00;
         done_q   <= 1'b0;
      end else begin
         if (state_q == adcsw_pkg::ADCSW_H_READ && cnt_q == 8'(STROBE_CYCLES - 1))
            result_q <= bus.bus_data;                                        // see [R17]
         if (state_q == adcsw_pkg::ADCSW_H_HOLD)
            done_q <= 1'b1;
         else if (wr_strobe && addr != 2'h2)
            done_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn)
         trig_q <= 1'b1;
      else if (wr_strobe && addr == 2'h2)
         trig_q <= wdata[0];
   end

   always_ff @(posedge clock) begin
      if (!resetn)
         rdata <= 8'h00;
      else if (rd_strobe)
         rdata <= addr == 2'h0 ? result_q : {5'h00, busy, done_q, bus.int_eoc_n};
      else
         rdata <= 8'h00;
   end

   assign bus.cs_n  = !busy;                                                 // see [R12]
   assign bus.wr_n  = !(state_q == adcsw_pkg::ADCSW_H_WRITE);                // see [R1]
   assign bus.rd_n  = !(state_q == adcsw_pkg::ADCSW_H_READ);                 // see [R5]
   assign bus.host_data    = wbuf_q;
   assign bus.host_data_oe = is_write_q && busy;
   assign bus.hardware_convert_trigger_n = trig_q;
   assign hardware_start_level = !trig_q;
endmodule
`default_nettype wire

// File: verification/adcsw_bus_sva.sv
// Timing checks on the host-converter bus
`timescale 1ns/1ps
`default_nettype none
module adcsw_bus_sva (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic rd_n,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic int_eoc_n,
   input wire logic conversion_clock_en,
   input wire logic internal_oscillator_run,
   input wire logic power_down
);
   logic       wr_q;
   logic       rd_q;
   logic       done_q;
   logic [3:0] samp_cnt_q;
   logic [3:0] conv_cnt_q;
   logic       rd_trig;
   logic       trig;
   logic       edge_any;
   // ----------------------------------------
   // Strobe edges and tick counters
   // ----------------------------------------
   assign rd_trig = !cs_n && rd_n && !rd_q;
   assign trig    = rd_trig || (!cs_n && wr_n && !wr_q);
   // Oscillator may start on the falling strobe edge as well
   assign edge_any = trig || (!wr_n && wr_q) || (!rd_n && rd_q);
   always_ff @(posedge clock) begin
      wr_q   <= !resetn || wr_n;
      rd_q   <= !resetn || rd_n;
      done_q <= resetn && (done_q || !int_eoc_n);
   end
   always_ff @(posedge clock) begin
      if (!resetn || (trig && int_eoc_n)) begin
         samp_cnt_q <= 4'h0;
      end else if (int_eoc_n && conversion_clock_en && samp_cnt_q != 4'hf) begin
         samp_cnt_q <= samp_cnt_q + 4'h1;
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn || int_eoc_n) begin
         conv_cnt_q <= 4'h0;
      end else if (conversion_clock_en) begin
         conv_cnt_q <= conv_cnt_q + 4'h1;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence s_conv_done;
      $rose(int_eoc_n);
   endsequence
   sequence s_no_read;
      rd_n [*8];
   endsequence
   property p_init;
      $rose(resetn) |-> int_eoc_n && !dev_data_oe;
   endproperty
   property p_sample_len;
      $fell(int_eoc_n) |-> samp_cnt_q == 4'h6;
   endproperty
   property p_conv_len;
      s_conv_done |-> conv_cnt_q == 4'ha;
   endproperty
   property p_osc_start;
      $rose(internal_oscillator_run) |-> $past(edge_any) || $past(edge_any, 2);
   endproperty
   property p_osc_stop;
      s_conv_done |-> ##[0:12] !internal_oscillator_run;
   endproperty
   property p_read_restart;
      rd_trig && done_q && int_eoc_n |-> ##[1:60] !int_eoc_n;
   endproperty
   property p_power_down;
      s_conv_done ##1 s_no_read |-> ##[0:8] power_down;
   endproperty
   property p_drive;
      (!cs_n && !rd_n) [*2] |-> dev_data_oe;
   endproperty
   property p_release;
      cs_n [*2] |-> !dev_data_oe;
   endproperty
   property p_no_clash;
      !(dev_data_oe && host_data_oe);
   endproperty
   property p_host_select;
      (!wr_n || !rd_n) |-> !cs_n;
   endproperty
   a_init: assert property (p_init) else $error("status line or bus drive wrong after reset");
   a_sample_len: assert property (p_sample_len) else $error("sampling not six ticks");
   a_conv_len: assert property (p_conv_len) else $error("conversion not ten ticks");
   a_osc_start: assert property (p_osc_start) else $error("oscillator started without trigger");
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator left running");
   a_read_restart: assert property (p_read_restart) else $error("read did not restart sampling");
   a_power_down: assert property (p_power_down) else $error("no power down without read");
   a_drive: assert property (p_drive) else $error("result not driven during read");
   a_release: assert property (p_release) else $error("bus driven while deselected");
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the bus");
   a_host_select: assert property (p_host_select) else $error("strobe without chip select");
endmodule
`default_nettype wire

// File: verification/adcsw_bench.sv
// Self-checking bench joining host and converter ends
`timescale 1ns/1ps
`default_nettype none
module adcsw_bench;
   logic       clock;
   logic       resetn;
   logic       external_clock_en;
   logic       ext_run;
   logic [1:0] ext_cnt;
   logic       wr_strobe;
   logic       rd_strobe;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] analog_sample;
   logic [7:0] seen_q;
   logic       internal_oscillator_run;
   logic       conversion_clock_en;
   logic       power_down;
   int         err_total;
   int         tests_run;
   adcsw_if adcsw_if_inst ();
   adcsw_device adcsw_device_inst (.clock(clock), .resetn(resetn), .bus(adcsw_if_inst),
      .external_clock_en(external_clock_en), .analog_sample(analog_sample),
      .internal_oscillator_run(internal_oscillator_run), .conversion_clock_en(conversion_clock_en),
      .power_down(power_down));
   adcsw_host adcsw_host_inst (.clock(clock), .resetn(resetn), .bus(adcsw_if_inst), .addr(addr),
      .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
      .hardware_start_level());
   adcsw_bus_sva adcsw_bus_sva_inst (.clock(clock), .resetn(resetn), .cs_n(adcsw_if_inst.cs_n),
      .wr_n(adcsw_if_inst.wr_n), .rd_n(adcsw_if_inst.rd_n), .host_data_oe(adcsw_if_inst.host_data_oe),
      .dev_data_oe(adcsw_if_inst.dev_data_oe), .int_eoc_n(adcsw_if_inst.int_eoc_n),
      .conversion_clock_en(conversion_clock_en), .internal_oscillator_run(internal_oscillator_run),
      .power_down(power_down));
   // ----------------------------------------
   // Clock, external tick, bus capture
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // External clock at a quarter of the bench clock, inside 1 to 20 MHz
   always @(posedge clock) begin
      if (!resetn) begin
         ext_cnt           <= 2'h0;
         external_clock_en <= 1'b0;
         seen_q            <= 8'h00;
      end else begin
         ext_cnt <= ext_cnt + 2'h1;
         external_clock_en <= ext_run && (ext_cnt == 2'h3);
         if (adcsw_if_inst.dev_data_oe) begin
            seen_q <= adcsw_if_inst.bus_data;
         end
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic host_op(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1'b1;
      @(posedge clock);
      wr_strobe <= 1'b0;
      repeat (5) @(posedge clock);
   endtask
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clock);
      rd_strobe <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic wait_eoc(input logic lvl, output int n);
      n = 0;
      while (adcsw_if_inst.int_eoc_n !== lvl && n < 200) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 200) begin
         err_total++;
         $display("unexpected at %0t: status line stuck", $time);
         conclude();
      end
   endtask
   // Whole conversion, checking the busy-low length in cycles:
   // ten ticks of the system clock, less the cycle the line takes to fall
   task automatic convert(input logic [7:0] cycles);
      int n;
      wait_eoc(1'b0, n);
      wait_eoc(1'b1, n);
      check(8'(n), cycles);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] d;
      resetn = 1'b0;
      ext_run = 1'b0;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      addr = 2'h0;
      wdata = 8'h00;
      analog_sample = 8'h38;
      err_total = 0;
      tests_run = 0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      #1;
      check({7'h00, adcsw_if_inst.int_eoc_n}, 8'h01);
      host_op(2'h0, 8'h80);
      host_op(2'h0, 8'h20);
      // Mode is now software start, so this write triggers sampling
      host_op(2'h0, 8'h20);
      convert(8'd49);
      repeat (12) @(posedge clock);
      #1;
      check({7'h00, power_down}, 8'h01);
      check({7'h00, internal_oscillator_run}, 8'h00);
      host_op(2'h1, 8'h00);
      check(seen_q, 8'h38);
      convert(8'd49);
      host_op(2'h0, 8'h92);
      repeat (90) @(posedge clock);
      // First result after power down is read and discarded
      host_op(2'h1, 8'h00);
      convert(8'd29);
      host_op(2'h1, 8'h00);
      check(seen_q, 8'hb8);
      repeat (90) @(posedge clock);
      ext_run <= 1'b1;
      host_op(2'h0, 8'h28);
      repeat (90) @(posedge clock);
      analog_sample <= 8'h81;
      host_op(2'h1, 8'h00);
      convert(8'd39);
      host_op(2'h1, 8'h00);
      check(seen_q, 8'h01);
      reg_rd(2'h1, d);
      check(d, 8'h03);
      reg_rd(2'h0, d);
      check(d, 8'h01);
      conclude();
   end
endmodule
`default_nettype wire
